// >>> inc/wrc_defs.svh
`ifndef WRC_DEFS_SVH
`define WRC_DEFS_SVH
// ****************************************
// register indices, byte address = 4 * index
// ****************************************
`define WRC_IDX_CFG     8'h11
`define WRC_IDX_PMODE   8'h1C
`define WRC_IDX_PORT    8'h29
`define WRC_IDX_STAT    8'h30
`define WRC_IDX_NONE    8'hFF
// ****************************************
// field positions
// ****************************************
`define WRC_CODE_MSB    3
`define WRC_CODE_LSB    0
`define WRC_SEL_MSB     6
`define WRC_SEL_LSB     4
`define WRC_PM_MSB      6
`define WRC_PM_LSB      4
`define WRC_ST_VALID    16
`define WRC_ST_SW       17
`define WRC_ST_MAN      18
// ****************************************
// reset values
// ****************************************
`define WRC_CFG_RST     8'h00
`define WRC_PM_RST      3'h0
`define WRC_BYTE_RST    8'h00
`define WRC_CNT_RST     16'h0000
// ****************************************
// rate codes and rates in hz
// ****************************************
`define WRC_CODE_SW     4'hF
`define WRC_HZ_ULP      {11'h514, 11'h44C, 11'h2EE, 11'h17C, 11'h0BE, 11'h064, 11'h032, 11'h019}
`define WRC_HZ_LP       {11'h2EE, 11'h258, 11'h190, 11'h0D2, 11'h069, 11'h036, 11'h01C, 11'h00E}
`define WRC_HZ_PREC     {11'h064, 11'h050, 11'h037, 11'h01C, 11'h00E}
`define WRC_ULP_LO      4'h6
`define WRC_ULP_HI      4'hC
`define WRC_LP_LO       4'h5
`define WRC_LP_HI       4'hB
`define WRC_PREC_LO     4'h5
`define WRC_PREC_HI     4'h8
`endif

// >>> inc/wrc_pkg.sv
package wrc_pkg;
  typedef enum logic [2:0] {
    pm_lp   = 3'b000,
    pm_ulp  = 3'b011,
    pm_prec = 3'b100
  } wrc_pmode_e;
  typedef enum logic [2:0] {
    sel_off  = 3'b000,
    sel_bias = 3'b001,
    sel_wfp  = 3'b010,
    sel_afp  = 3'b011,
    sel_wcl  = 3'b100,
    sel_wch  = 3'b101,
    sel_acl  = 3'b110,
    sel_ach  = 3'b111
  } wrc_sel_e;
  typedef enum logic {
    bus_idle = 1'b0,
    bus_data = 1'b1
  } wrc_bus_e;
endpackage

// >>> rtl/wrc_rate_decode.sv
`timescale 1ns/100ps
`include "wrc_defs.svh"
module wrc_rate_decode (
  input  wire logic [2:0]  power_mode,
  input  wire logic [3:0]  rate_code,
  output logic      [10:0] rate_hz,
  output logic             rate_valid
);
  // ****************************************
  // rate tables per power mode
  // ****************************************
  localparam logic [87:0] HZ_ULP  = `WRC_HZ_ULP;
  localparam logic [87:0] HZ_LP   = `WRC_HZ_LP;
  localparam logic [54:0] HZ_PREC = `WRC_HZ_PREC;
  logic [3:0] off_ulp;
  logic [3:0] off_lp;
  logic [3:0] off_prec;
  logic       is_sw;
  assign off_ulp  = rate_code - `WRC_ULP_LO;
  assign off_lp   = rate_code - `WRC_LP_LO;
  assign off_prec = rate_code - `WRC_PREC_LO;
  assign is_sw    = (rate_code == `WRC_CODE_SW);
  always_comb begin
    rate_hz    = 11'h000;
    rate_valid = 1'b0;
    case (power_mode)
      wrc_pkg::pm_ulp: begin
        if (is_sw) begin
          rate_hz    = HZ_ULP[77 +: 11];
          rate_valid = 1'b1;
        end else if (rate_code >= `WRC_ULP_LO && rate_code <= `WRC_ULP_HI) begin
          rate_hz    = HZ_ULP[11*off_ulp[2:0] +: 11];
          rate_valid = 1'b1;
        end
      end
      wrc_pkg::pm_lp: begin
        if (is_sw) begin
          rate_hz    = HZ_LP[77 +: 11];
          rate_valid = 1'b1;
        end else if (rate_code >= `WRC_LP_LO && rate_code <= `WRC_LP_HI) begin
          rate_hz    = HZ_LP[11*off_lp[2:0] +: 11];
          rate_valid = 1'b1;
        end
      end
      wrc_pkg::pm_prec: begin
        if (is_sw) begin
          rate_hz    = HZ_PREC[44 +: 11];
          rate_valid = 1'b1;
        end else if (rate_code >= `WRC_PREC_LO && rate_code <= `WRC_PREC_HI) begin
          rate_hz    = HZ_PREC[11*off_prec[1:0] +: 11];
          rate_valid = 1'b1;
        end
      end
      default: begin
        rate_hz    = 11'h000;
        rate_valid = 1'b0;
      end
    endcase
  end
endmodule

// >>> rtl/wrc_top.sv
// Function
// - the wake sampling rate comes from the rate configuration register.
// - each rate code is read according to the power mode (ulp 3, lp 0, precision 4).
// - in ultra-low power codes 6 to C give 25 to 1100 Hz and code 5 is unsupported.
// - in low power codes 5 to B give 14 to 600 Hz and code C is unsupported.
// - in precision codes 5 to 8 give 14 to 80 Hz and codes 9 to C are unsupported.
// - code F is the software-defined rate, 1300, 750 or 100 Hz by mode, after setup.
// - rate code sits in bits 3:0, manual select in 6:4, reserved bit 7.
// - a manual select of zero turns manual rate mode off.
// - a nonzero manual select picks the tuning register seen through the port.
// - select 1 maps both bias trims, selects 2 and 3 the 5-bit frequency picks.
// - selects 4 to 7 reach the low and high bytes of the two clock counts.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/100ps
`include "wrc_defs.svh"
module wrc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [3:0]  wake_rate_code,
  output logic      [2:0]  manual_rate_select,
  output logic      [2:0]  power_mode,
  output logic      [10:0] wake_rate_hz,
  output logic             wake_rate_valid,
  output logic             sw_rate_active,
  output logic             manual_rate_mode,
  output logic      [3:0]  activity_watch_bias_trim,
  output logic      [3:0]  wake_bias_trim,
  output logic      [4:0]  wake_frequency_pick,
  output logic      [4:0]  activity_watch_frequency_pick,
  output logic      [15:0] wake_rate_clk_count,
  output logic      [15:0] activity_watch_clk_count
);
  // ****************************************
  // bus state
  // ****************************************
  wrc_pkg::wrc_bus_e bus_q;
  wrc_pkg::wrc_bus_e bus_d;
  logic              wr_q;
  logic [7:0]        idx_q;
  logic [7:0]        idx_d;
  logic              hready_q;
  logic [31:0]       hrdata_q;
  logic              take;
  logic              dph;
  logic              wr_en;
  logic              rd_en;
  logic [31:0]       rd_mux;
  // ****************************************
  // registers
  // ****************************************
  logic [3:0]        code_q;
  logic [2:0]        sel_q;
  logic [2:0]        pmode_q;
  logic [10:0]       hz_q;
  logic              valid_q;
  logic              sw_q;
  logic              man_q;
  logic [3:0]        atrim_q;
  logic [3:0]        wtrim_q;
  logic [4:0]        wfp_q;
  logic [4:0]        afp_q;
  logic [15:0]       wcnt_q;
  logic [15:0]       acnt_q;
  logic [10:0]       dec_hz;
  logic              dec_valid;
  logic              cfg_we;
  logic              pm_we;
  logic              port_we;
  logic [7:0]        port_rd;
  logic [31:0]       stat_rd;
  localparam logic [7:0] CFG_RST_VAL = `WRC_CFG_RST;

  // ****************************************
  // tuning port read
  // ****************************************
  function automatic logic [7:0] port_read(
    input logic [2:0]  sel,
    input logic [3:0]  atrim,
    input logic [3:0]  wtrim,
    input logic [4:0]  wfp,
    input logic [4:0]  afp,
    input logic [15:0] wcnt,
    input logic [15:0] acnt
  );
    logic [7:0] r;
    r = 8'h00;
    case (sel)
      wrc_pkg::sel_bias: r = {atrim, wtrim};
      wrc_pkg::sel_wfp:  r = {3'h0, wfp};
      wrc_pkg::sel_afp:  r = {3'h0, afp};
      wrc_pkg::sel_wcl:  r = wcnt[7:0];
      wrc_pkg::sel_wch:  r = wcnt[15:8];
      wrc_pkg::sel_acl:  r = acnt[7:0];
      wrc_pkg::sel_ach:  r = acnt[15:8];
      default:           r = 8'h00;
    endcase
    return r;
  endfunction

  // ****************************************
  // address and data phase decode
  // ****************************************
  assign take  = hsel & htrans[1] & hready;
  assign idx_d = (haddr[31:10] == 22'h0) ? haddr[9:2] : `WRC_IDX_NONE;
  assign bus_d = take ? wrc_pkg::bus_data : wrc_pkg::bus_idle;
  assign dph   = (bus_q == wrc_pkg::bus_data);
  assign wr_en = dph & wr_q;
  assign rd_en = dph & ~wr_q;

  assign cfg_we  = wr_en & (idx_q == `WRC_IDX_CFG);
  assign pm_we   = wr_en & (idx_q == `WRC_IDX_PMODE);
  assign port_we = wr_en & (idx_q == `WRC_IDX_PORT) & (sel_q != wrc_pkg::sel_off);

  assign port_rd = port_read(sel_q, atrim_q, wtrim_q, wfp_q, afp_q, wcnt_q, acnt_q);
  assign stat_rd = {13'h0000, man_q, sw_q, valid_q, 5'h00, hz_q};

  assign rd_mux =
    (idx_q == `WRC_IDX_CFG)   ? {24'h000000, 1'b0, sel_q, code_q} :
    (idx_q == `WRC_IDX_PMODE) ? {24'h000000, 1'b0, pmode_q, 4'h0} :
    (idx_q == `WRC_IDX_PORT)  ? {24'h000000, port_rd} :
    (idx_q == `WRC_IDX_STAT)  ? stat_rd :
                                32'h00000000;

  // ****************************************
  // bus slave, one wait cycle per transfer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q    <= wrc_pkg::bus_idle;
      wr_q     <= 1'b0;
      idx_q    <= `WRC_IDX_NONE;
      hready_q <= 1'b1;
    end else begin
      bus_q    <= bus_d;
      hready_q <= ~take;
      if (take) begin
        wr_q  <= hwrite;
        idx_q <= idx_d;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_en) begin
      hrdata_q <= rd_mux;
    end
  end

  // ****************************************
  // rate configuration and power mode
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_q  <= CFG_RST_VAL[`WRC_CODE_MSB:`WRC_CODE_LSB];
      sel_q   <= CFG_RST_VAL[`WRC_SEL_MSB:`WRC_SEL_LSB];
      pmode_q <= `WRC_PM_RST;
    end else begin
      if (cfg_we) begin
        code_q <= hwdata[`WRC_CODE_MSB:`WRC_CODE_LSB];
        sel_q  <= hwdata[`WRC_SEL_MSB:`WRC_SEL_LSB];
      end
      if (pm_we) begin
        pmode_q <= hwdata[`WRC_PM_MSB:`WRC_PM_LSB];
      end
    end
  end

  // ****************************************
  // rate decode
  // ****************************************
  wrc_rate_decode u_dec (
    .power_mode (pmode_q),
    .rate_code  (code_q),
    .rate_hz    (dec_hz),
    .rate_valid (dec_valid)
  );

  // bit 7 never reaches the decode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hz_q    <= 11'h000;
      valid_q <= 1'b0;
      sw_q    <= 1'b0;
      man_q   <= 1'b0;
    end else begin
      hz_q    <= dec_hz;
      valid_q <= dec_valid;
      sw_q    <= (code_q == `WRC_CODE_SW);
      man_q   <= (sel_q != wrc_pkg::sel_off);
    end
  end

  // ****************************************
  // hidden tuning registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      atrim_q <= 4'h0;
      wtrim_q <= 4'h0;
      wfp_q   <= 5'h00;
      afp_q   <= 5'h00;
    end else if (port_we) begin
      if (sel_q == wrc_pkg::sel_bias) begin
        atrim_q <= hwdata[7:4];
        wtrim_q <= hwdata[3:0];
      end
      if (sel_q == wrc_pkg::sel_wfp) begin
        wfp_q <= hwdata[4:0];
      end
      if (sel_q == wrc_pkg::sel_afp) begin
        afp_q <= hwdata[4:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wcnt_q <= `WRC_CNT_RST;
      acnt_q <= `WRC_CNT_RST;
    end else if (port_we) begin
      if (sel_q == wrc_pkg::sel_wcl) begin
        wcnt_q[7:0] <= hwdata[7:0];
      end
      if (sel_q == wrc_pkg::sel_wch) begin
        wcnt_q[15:8] <= hwdata[7:0];
      end
      if (sel_q == wrc_pkg::sel_acl) begin
        acnt_q[7:0] <= hwdata[7:0];
      end
      if (sel_q == wrc_pkg::sel_ach) begin
        acnt_q[15:8] <= hwdata[7:0];
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hrdata                        = hrdata_q;
  assign hreadyout                     = hready_q;
  assign hresp                         = 1'b0;
  assign wake_rate_code                = code_q;
  assign manual_rate_select            = sel_q;
  assign power_mode                    = pmode_q;
  assign wake_rate_hz                  = hz_q;
  assign wake_rate_valid               = valid_q;
  assign sw_rate_active                = sw_q;
  assign manual_rate_mode              = man_q;
  assign activity_watch_bias_trim      = atrim_q;
  assign wake_bias_trim                = wtrim_q;
  assign wake_frequency_pick           = wfp_q;
  assign activity_watch_frequency_pick = afp_q;
  assign wake_rate_clk_count           = wcnt_q;
  assign activity_watch_clk_count      = acnt_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_cfg_read;
    take && !hwrite && (idx_d == `WRC_IDX_CFG);
  endsequence

  sequence s_port_wr(logic [2:0] s);
    cfg_we ##1 (!cfg_we && !pm_we)[*1] ##0 (port_we && sel_q == s);
  endsequence

  a_cfg_code_store: assert property (
    cfg_we |=> (wake_rate_code == $past(hwdata[3:0]))
  ) else $error("rate code not stored");

  a_mode_bad_invalid: assert property (
    (pmode_q != 3'b000 && pmode_q != 3'b011 && pmode_q != 3'b100)
      |=> !wake_rate_valid
  ) else $error("unknown power mode gave a valid rate");

  a_ulp_rate_ends: assert property (
    ((pmode_q == 3'b011 && code_q == 4'h6) |=> (wake_rate_hz == 11'h019 && wake_rate_valid))
    and
    ((pmode_q == 3'b011 && code_q == 4'h5) |=> !wake_rate_valid)
  ) else $error("ultra-low power rate wrong");

  a_lp_rate_ends: assert property (
    ((pmode_q == 3'b000 && code_q == 4'hB) |=> (wake_rate_hz == 11'h258 && wake_rate_valid))
    and
    ((pmode_q == 3'b000 && code_q == 4'hC) |=> !wake_rate_valid)
  ) else $error("low power rate wrong");

  a_prec_rate_ends: assert property (
    ((pmode_q == 3'b100 && code_q == 4'h8) |=> (wake_rate_hz == 11'h050 && wake_rate_valid))
    and
    ((pmode_q == 3'b100 && code_q == 4'h9) |=> !wake_rate_valid)
  ) else $error("precision rate wrong");

  a_sw_rate_flag: assert property (
    (code_q == 4'hF && pmode_q == 3'b011)
      |=> (sw_rate_active && wake_rate_hz == 11'h514)
  ) else $error("software rate not flagged");

  a_cfg_read_layout: assert property (
    s_cfg_read ##1 1'b1
      |=> (hreadyout && hrdata[31:7] == 25'h0000000
           && hrdata[6:0] == {$past(sel_q), $past(code_q)})
  ) else $error("config read layout wrong");

  a_sel_off_locks: assert property (
    (wr_en && idx_q == `WRC_IDX_PORT && sel_q == 3'b000)
      |=> ($stable(wcnt_q) && $stable(acnt_q) && $stable(wfp_q) && !manual_rate_mode)
  ) else $error("port write with select off changed state");

  a_wcnt_low_wr: assert property (
    (port_we && sel_q == 3'b100)
      |=> (wake_rate_clk_count[7:0] == $past(hwdata[7:0])) ##1 $stable(wcnt_q[15:8])
  ) else $error("wake count low byte not written");

  a_fpick_wr: assert property (
    (port_we && sel_q == 3'b010) |=> (wake_frequency_pick == $past(hwdata[4:0]))
  ) else $error("wake frequency pick not written");

  a_acnt_high_wr: assert property (
    (port_we && sel_q == 3'b111) |=> (activity_watch_clk_count[15:8] == $past(hwdata[7:0]))
  ) else $error("activity count high byte not written");

  a_bus_one_wait: assert property (
    take |=> !hreadyout ##1 hreadyout
  ) else $error("bus wait cycle wrong");

endmodule

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`include "wrc_defs.svh"
module tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  wake_rate_code;
  logic [2:0]  manual_rate_select;
  logic [2:0]  power_mode;
  logic [10:0] wake_rate_hz;
  logic        wake_rate_valid;
  logic        sw_rate_active;
  logic        manual_rate_mode;
  logic [3:0]  activity_watch_bias_trim;
  logic [3:0]  wake_bias_trim;
  logic [4:0]  wake_frequency_pick;
  logic [4:0]  activity_watch_frequency_pick;
  logic [15:0] wake_rate_clk_count;
  logic [15:0] activity_watch_clk_count;
  int          mismatches;
  int          comparisons;
  logic [31:0] rd;
  logic [10:0] e;
  localparam logic [10:0] ULP_HZ [7] = '{11'h019, 11'h032, 11'h064, 11'h0BE, 11'h17C,
                                         11'h2EE, 11'h44C};
  localparam logic [10:0] LP_HZ [7]  = '{11'h00E, 11'h01C, 11'h036, 11'h069, 11'h0D2,
                                         11'h190, 11'h258};
  localparam logic [10:0] PR_HZ [4]  = '{11'h00E, 11'h01C, 11'h037, 11'h050};
  localparam logic [2:0]  MODES [4]  = '{3'h3, 3'h0, 3'h4, 3'h1};
  localparam logic [7:0]  PV [7]     = '{8'hA5, 8'hFF, 8'hEA, 8'h34, 8'h12, 8'h78, 8'h56};
  localparam logic [7:0]  PE [7]     = '{8'hA5, 8'h1F, 8'h0A, 8'h34, 8'h12, 8'h78, 8'h56};
  // ****************************************
  // design and clock
  // ****************************************
  wrc_top i_dut (
    .hclk                          (hclk),
    .hresetn                       (hresetn),
    .hsel                          (hsel),
    .haddr                         (haddr),
    .htrans                        (htrans),
    .hwrite                        (hwrite),
    .hsize                         (hsize),
    .hwdata                        (hwdata),
    .hready                        (hreadyout),
    .hrdata                        (hrdata),
    .hreadyout                     (hreadyout),
    .hresp                         (hresp),
    .wake_rate_code                (wake_rate_code),
    .manual_rate_select            (manual_rate_select),
    .power_mode                    (power_mode),
    .wake_rate_hz                  (wake_rate_hz),
    .wake_rate_valid               (wake_rate_valid),
    .sw_rate_active                (sw_rate_active),
    .manual_rate_mode              (manual_rate_mode),
    .activity_watch_bias_trim      (activity_watch_bias_trim),
    .wake_bias_trim                (wake_bias_trim),
    .wake_frequency_pick           (wake_frequency_pick),
    .activity_watch_frequency_pick (activity_watch_frequency_pick),
    .wake_rate_clk_count           (wake_rate_clk_count),
    .activity_watch_clk_count      (activity_watch_clk_count)
  );
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one single transfer, entered and left at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    hsel   <= 1'b1;
    haddr  <= {22'h000000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) mismatches++;
    rd = hrdata;
    chk(hresp, 32'h0);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
    repeat (2) @(posedge hclk);
  endtask
  task automatic rdx(input logic [7:0] idx);
    xfer(1'b0, idx, 32'h0);
  endtask
  function automatic logic [10:0] exp_hz(input logic [2:0] m, input logic [3:0] c);
    logic [10:0] r;
    r = 11'h000;
    if (m == 3'h3) begin
      if (c == 4'hF) r = 11'h514;
      else if (c >= 4'h6 && c <= 4'hC) r = ULP_HZ[c - 4'h6];
    end else if (m == 3'h0) begin
      if (c == 4'hF) r = 11'h2EE;
      else if (c >= 4'h5 && c <= 4'hB) r = LP_HZ[c - 4'h5];
    end else if (m == 3'h4) begin
      if (c == 4'hF) r = 11'h064;
      else if (c >= 4'h5 && c <= 4'h8) r = PR_HZ[c - 4'h5];
    end
    return r;
  endfunction
  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    mismatches = 0; comparisons = 0;
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({wake_rate_code, manual_rate_select, power_mode, wake_rate_hz}, 32'h0);
    chk({wake_rate_valid, sw_rate_active, manual_rate_mode}, 32'h0);
    chk({wake_rate_clk_count, activity_watch_clk_count}, 32'h0);
    rdx(`WRC_IDX_CFG); chk(rd, 32'h0);
    for (int mi = 0; mi < 4; mi++) begin
      wr(`WRC_IDX_PMODE, {25'h0, MODES[mi], 4'h0});
      rdx(`WRC_IDX_PMODE); chk(rd, {25'h0, MODES[mi], 4'h0});
      for (int c = 0; c < 16; c++) begin
        wr(`WRC_IDX_CFG, {28'h0, c[3:0]});
        e = exp_hz(MODES[mi], c[3:0]);
        chk(wake_rate_hz, e);
        chk(wake_rate_valid, e != 11'h000);
        chk(sw_rate_active, c == 15);
        chk({power_mode, wake_rate_code}, {MODES[mi], c[3:0]});
        rdx(`WRC_IDX_STAT);
        chk(rd, {13'h0, 1'b0, c == 15, e != 11'h000, 5'h0, e});
      end
    end
    wr(`WRC_IDX_PMODE, 32'h30);
    wr(`WRC_IDX_CFG, 32'hFF);
    rdx(`WRC_IDX_CFG); chk(rd, 32'h7F);
    chk({wake_rate_valid, wake_rate_hz}, {1'b1, 11'h514});
    chk({manual_rate_mode, manual_rate_select}, 4'hF);
    wr(`WRC_IDX_CFG, 32'h08);
    wr(`WRC_IDX_PORT, 32'h5A);
    rdx(`WRC_IDX_PORT); chk(rd, 32'h0);
    chk({manual_rate_mode, wake_rate_hz}, {1'b0, 11'h064});
    chk({activity_watch_bias_trim, wake_bias_trim, wake_rate_clk_count}, 32'h0);
    for (int s = 1; s < 8; s++) begin
      wr(`WRC_IDX_CFG, {25'h0, s[2:0], 4'h6});
      wr(`WRC_IDX_PORT, {24'h0, PV[s - 1]});
      rdx(`WRC_IDX_PORT); chk(rd, {24'h0, PE[s - 1]});
      chk({manual_rate_mode, manual_rate_select}, {1'b1, s[2:0]});
    end
    chk({activity_watch_bias_trim, wake_bias_trim}, 8'hA5);
    chk({wake_frequency_pick, activity_watch_frequency_pick}, 10'h3EA);
    chk(wake_rate_clk_count, 16'h1234);
    chk(activity_watch_clk_count, 16'h5678);
    for (int s = 7; s > 0; s--) begin
      wr(`WRC_IDX_CFG, {25'h0, s[2:0], 4'h6});
      rdx(`WRC_IDX_PORT); chk(rd, {24'h0, PE[s - 1]});
    end
    wr(8'h05, 32'hFF);
    rdx(8'h05); chk(rd, 32'h0);
    wr(`WRC_IDX_STAT, 32'h0);
    rdx(`WRC_IDX_STAT); chk(rd, {13'h0, 1'b1, 1'b0, 1'b1, 5'h0, 11'h019});
    rdx(`WRC_IDX_CFG); chk(rd, 32'h16);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    chk({wake_rate_code, manual_rate_select, power_mode, wake_rate_hz}, 32'h0);
    chk({hreadyout, wake_rate_valid, manual_rate_mode}, 32'h4);
    chk({wake_rate_clk_count, activity_watch_clk_count}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdx(`WRC_IDX_CFG); chk(rd, 32'h0);
    end_sim();
  end
endmodule
